// ===== instr_decoder.sv
/*
 * Decode and execution control for the 14-bit instruction word: owns the
 * working register and status flags, drives register file, program memory
 * table reads and program-flow requests.
 * Assumes register file read data follows o_file.addr combinationally and
 * program memory data stands in the cycle in which o_rom.rd is high.
 */
`timescale 1ns/100ps

module instr_decoder
    import instr_decoder_pkg::*;
(
    input  wire logic         i_clk,         // 200 MHz instruction clock
    input  wire logic         i_reset_n,     // async reset, active low
    input  wire logic         i_instr_valid, // instruction word offered
    input  wire logic [13:0]  i_instr,       // instruction word
    output logic              o_ready,       // decoder takes a word
    input  wire logic [7:0]   i_file_rdata,  // register file read data
    output file_req_t         o_file,        // register file address and write
    input  wire logic [9:0]   i_table_ptr,   // table read pointer
    input  wire logic [13:0]  i_rom_data,    // program memory word
    output rom_req_t          o_rom,         // table read request
    output flow_t             o_flow,        // program counter requests
    output logic [7:0]        o_w,           // working register
    output status_t           o_status,      // status flags
    output logic              o_sleep,       // enter power-down pulse
    output logic              o_wdt_restart, // watchdog restart pulse
    output logic              o_done,        // instruction retired pulse
    output logic [1:0]        o_cycles       // cycles of last instruction
);

    seq_state_t  state_ff, nxt_state;
    logic [13:0] instr_ff, nxt_instr;
    logic        ready_ff, nxt_ready;
    file_req_t   file_ff, nxt_file;
    rom_req_t    rom_ff, nxt_rom;
    flow_t       flow_ff, nxt_flow;
    logic [7:0]  w_ff, nxt_w;
    status_t     st_ff, nxt_st;
    logic        sleep_ff, nxt_sleep;
    logic        wdt_ff, nxt_wdt;
    logic        done_ff, nxt_done;
    logic [1:0]  cycles_ff, nxt_cycles;
    logic        tab_pend_ff, nxt_tab_pend;
    logic        tab_hi_ff, nxt_tab_hi;

    // 8-bit add with carry-in, returns {carry, nibble carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
        logic [8:0] s;
        logic [4:0] h;
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {s[8], h[4], s[7:0]};
    endfunction

    // operand address: byte ops use 7 bits, all others 6
    function automatic logic [6:0] oper_addr(input logic [13:0] ins);
        if (ins[13:12] == CLS_BYTE) begin
            return ins[6:0];
        end else begin
            return {1'b0, ins[5:0]};
        end
    endfunction

    always_comb begin
        logic [7:0] f;
        logic [7:0] k;
        logic [7:0] res;
        logic [7:0] mask;
        logic [9:0] alu;
        logic       d;
        logic       use_d;
        logic       to_w;
        logic       to_f;
        logic       set_z;
        logic       skip;
        logic       two;
        f     = i_file_rdata;
        k     = instr_ff[7:0];
        res   = f;
        mask  = 8'h01 << instr_ff[8:BSEL_LSB];
        alu   = 10'h000;
        d     = instr_ff[DEST_BIT];
        use_d = 1'b0;
        to_w  = 1'b0;
        to_f  = 1'b0;
        set_z = 1'b0;
        skip  = 1'b0;
        two   = 1'b0;

        nxt_state    = state_ff;
        nxt_instr    = instr_ff;
        nxt_ready    = ready_ff;
        nxt_file     = file_ff;
        nxt_file.we  = 1'b0;
        nxt_rom      = rom_ff;
        nxt_rom.rd   = 1'b0;
        nxt_flow     = '0;
        nxt_w        = w_ff;
        nxt_st       = st_ff;
        nxt_sleep    = 1'b0;
        nxt_wdt      = 1'b0;
        nxt_done     = 1'b0;
        nxt_cycles   = cycles_ff;
        nxt_tab_pend = tab_pend_ff;
        nxt_tab_hi   = tab_hi_ff;

        case (state_ff)
            S_IDLE: begin
                if (ready_ff && i_instr_valid) begin
                    nxt_instr       = i_instr;
                    nxt_file.addr   = oper_addr(i_instr);
                    nxt_file.rplane = (i_instr[13:12] == CLS_LIT) && (i_instr[11:9] == 3'h7);
                    nxt_ready       = 1'b0;
                    nxt_state       = S_EXEC;
                end
            end
            S_EXEC: begin
                case (instr_ff[13:12])
                    CLS_BYTE: begin
                        case (instr_ff[11:8])
                            OP_MISC: begin
                                if (d) begin
                                    res  = w_ff;
                                    to_f = 1'b1;
                                end else if (instr_ff == WORD_SUBRET) begin
                                    nxt_flow.pop = 1'b1;
                                    two          = 1'b1;
                                end else if (instr_ff == WORD_INTRET) begin
                                    nxt_flow.pop     = 1'b1;
                                    nxt_flow.int_ret = 1'b1;
                                    two              = 1'b1;
                                end else if (instr_ff == WORD_TABH ||
                                             instr_ff == WORD_TABL) begin
                                    nxt_rom.rd   = 1'b1;
                                    nxt_rom.addr = i_table_ptr;
                                    nxt_tab_pend = 1'b1;
                                    nxt_tab_hi   = (instr_ff == WORD_TABH);
                                    two          = 1'b1;
                                end
                            end
                            OP_CLR: begin
                                res   = 8'h00;
                                use_d = 1'b1;
                                set_z = 1'b1;
                            end
                            OP_SUB, OP_ADD: begin
                                alu    = (instr_ff[11:8] == OP_SUB) ? add8(f, ~w_ff, 1'b1)
                                                                    : add8(f, w_ff, 1'b0);
                                res    = alu[7:0];
                                nxt_st.c  = alu[9];
                                nxt_st.decimal_carry_flag = alu[8];
                                use_d  = 1'b1;
                                set_z  = 1'b1;
                            end
                            OP_DEC, OP_DECSZ: begin
                                res   = f - 8'h01;
                                use_d = 1'b1;
                                set_z = (instr_ff[11:8] == OP_DEC);
                                skip  = (instr_ff[11:8] == OP_DECSZ) && (res == 8'h00);
                            end
                            OP_INC, OP_INCSZ: begin
                                res   = f + 8'h01;
                                use_d = 1'b1;
                                set_z = (instr_ff[11:8] == OP_INC);
                                skip  = (instr_ff[11:8] == OP_INCSZ) && (res == 8'h00);
                            end
                            OP_OR: begin
                                res   = f | w_ff;
                                use_d = 1'b1;
                                set_z = 1'b1;
                            end
                            OP_AND: begin
                                res   = f & w_ff;
                                use_d = 1'b1;
                                set_z = 1'b1;
                            end
                            OP_XOR: begin
                                res   = f ^ w_ff;
                                use_d = 1'b1;
                                set_z = 1'b1;
                            end
                            OP_MOVF: begin
                                to_w  = ~d;
                                set_z = d;
                            end
                            OP_COM: begin
                                res   = ~f;
                                use_d = 1'b1;
                                set_z = 1'b1;
                            end
                            OP_RRC: begin
                                res      = {st_ff.c, f[7:1]};
                                nxt_st.c = f[0];
                                use_d    = 1'b1;
                            end
                            OP_RLC: begin
                                res      = {f[6:0], st_ff.c};
                                nxt_st.c = f[7];
                                use_d    = 1'b1;
                            end
                            default: begin
                                res   = {f[3:0], f[7:4]};
                                use_d = 1'b1;
                            end
                        endcase
                        if (use_d) begin
                            to_w = ~d;
                            to_f = d;
                        end
                    end
                    CLS_LIT: begin
                        if (!instr_ff[11]) begin
                            case (instr_ff[10:9])
                                BIT_CLR: begin
                                    res  = f & ~mask;
                                    to_f = 1'b1;
                                end
                                BIT_SET: begin
                                    res  = f | mask;
                                    to_f = 1'b1;
                                end
                                BIT_TSC: skip = ((f & mask) == 8'h00);
                                default: skip = ((f & mask) != 8'h00);
                            endcase
                        end else begin
                            case (instr_ff[11:8])
                                OP_RETLIT: begin
                                    res          = k;
                                    to_w         = 1'b1;
                                    nxt_flow.pop = 1'b1;
                                    two          = 1'b1;
                                end
                                OP_LOADLIT: begin
                                    res  = k;
                                    to_w = 1'b1;
                                end
                                OP_ORLIT: begin
                                    res   = w_ff | k;
                                    to_w  = 1'b1;
                                    set_z = 1'b1;
                                end
                                OP_ANDLIT: begin
                                    res   = w_ff & k;
                                    to_w  = 1'b1;
                                    set_z = 1'b1;
                                end
                                OP_ADDLIT: begin
                                    alu       = add8(w_ff, k, 1'b0);
                                    res       = alu[7:0];
                                    nxt_st.c  = alu[9];
                                    nxt_st.decimal_carry_flag = alu[8];
                                    to_w      = 1'b1;
                                    set_z     = 1'b1;
                                end
                                OP_XORLIT: begin
                                    res   = w_ff ^ k;
                                    to_w  = 1'b1;
                                    set_z = 1'b1;
                                end
                                OP_TO_R: begin
                                    if (instr_ff == WORD_SLEEP) begin
                                        nxt_sleep = 1'b1;
                                        nxt_st.time_out_flag   = 1'b1;
                                        nxt_st.power_down_flag = 1'b0;
                                    end else if (instr_ff == WORD_WDT) begin
                                        nxt_wdt   = 1'b1;
                                        nxt_st.time_out_flag   = 1'b1;
                                        nxt_st.power_down_flag = 1'b1;
                                    end else begin
                                        res  = w_ff;
                                        to_f = 1'b1;
                                    end
                                end
                                default: to_w = 1'b1;
                            endcase
                        end
                    end
                    default: begin
                        nxt_flow.push   = (instr_ff[13:12] == CLS_CALL);
                        nxt_flow.jump   = 1'b1;
                        nxt_flow.target = instr_ff[11:0];
                        two             = 1'b1;
                    end
                endcase
                if (set_z) begin
                    nxt_st.z = (res == 8'h00);
                end
                if (to_w) begin
                    nxt_w = res;
                end
                nxt_file.we    = to_f;
                nxt_file.wdata = res;
                if (skip) begin
                    nxt_flow.skip = 1'b1;
                    two           = 1'b1;
                end
                if (two) begin
                    nxt_state = S_SECOND;
                end else begin
                    nxt_state  = S_IDLE;
                    nxt_ready  = 1'b1;
                    nxt_done   = 1'b1;
                    nxt_cycles = CYC_ONE;
                end
            end
            default: begin
                if (tab_pend_ff) begin
                    nxt_w = tab_hi_ff ? {2'h0, i_rom_data[13:8]} : i_rom_data[7:0];
                end
                nxt_tab_pend = 1'b0;
                nxt_state    = S_IDLE;
                nxt_ready    = 1'b1;
                nxt_done     = 1'b1;
                nxt_cycles   = CYC_TWO;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff    <= S_IDLE;
            instr_ff    <= 14'h0000;
            ready_ff    <= 1'b1;
            file_ff     <= '0;
            rom_ff      <= '0;
            flow_ff     <= '0;
            w_ff        <= W_RST;
            st_ff       <= '{TIME_OUT_RST, POWER_DOWN_RST, 1'b0, 1'b0, 1'b0};
            sleep_ff    <= 1'b0;
            wdt_ff      <= 1'b0;
            done_ff     <= 1'b0;
            cycles_ff   <= 2'h0;
            tab_pend_ff <= 1'b0;
            tab_hi_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            instr_ff    <= nxt_instr;
            ready_ff    <= nxt_ready;
            file_ff     <= nxt_file;
            rom_ff      <= nxt_rom;
            flow_ff     <= nxt_flow;
            w_ff        <= nxt_w;
            st_ff       <= nxt_st;
            sleep_ff    <= nxt_sleep;
            wdt_ff      <= nxt_wdt;
            done_ff     <= nxt_done;
            cycles_ff   <= nxt_cycles;
            tab_pend_ff <= nxt_tab_pend;
            tab_hi_ff   <= nxt_tab_hi;
        end
    end

    assign o_ready       = ready_ff;
    assign o_file        = file_ff;
    assign o_rom         = rom_ff;
    assign o_flow        = flow_ff;
    assign o_w           = w_ff;
    assign o_status      = st_ff;
    assign o_sleep       = sleep_ff;
    assign o_wdt_restart = wdt_ff;
    assign o_done        = done_ff;
    assign o_cycles      = cycles_ff;

endmodule // instr_decoder

// ===== instr_decoder_pkg.sv
/*
 * Shared constants, states and carrier types for the instruction decoder.
 * Assumes a 14-bit program word and an 8-bit data path on one clock.
 */
package instr_decoder_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 12;
    localparam int ROM_AW  = 10;

    // instruction classes, bits 13:12
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_LIT  = 2'h1;
    localparam logic [1:0] CLS_CALL = 2'h2;
    localparam logic [1:0] CLS_JUMP = 2'h3;

    // byte-oriented operation, bits 11:8
    localparam logic [3:0] OP_MISC  = 4'h0;
    localparam logic [3:0] OP_CLR   = 4'h1;
    localparam logic [3:0] OP_SUB   = 4'h2;
    localparam logic [3:0] OP_DEC   = 4'h3;
    localparam logic [3:0] OP_OR    = 4'h4;
    localparam logic [3:0] OP_AND   = 4'h5;
    localparam logic [3:0] OP_XOR   = 4'h6;
    localparam logic [3:0] OP_ADD   = 4'h7;
    localparam logic [3:0] OP_MOVF  = 4'h8;
    localparam logic [3:0] OP_COM   = 4'h9;
    localparam logic [3:0] OP_INC   = 4'ha;
    localparam logic [3:0] OP_DECSZ = 4'hb;
    localparam logic [3:0] OP_RRC   = 4'hc;
    localparam logic [3:0] OP_RLC   = 4'hd;
    localparam logic [3:0] OP_SWAP  = 4'he;
    localparam logic [3:0] OP_INCSZ = 4'hf;

    // literal and control operation, bits 11:8
    localparam logic [3:0] OP_RETLIT  = 4'h8;
    localparam logic [3:0] OP_LOADLIT = 4'h9;
    localparam logic [3:0] OP_ORLIT   = 4'ha;
    localparam logic [3:0] OP_ANDLIT  = 4'hb;
    localparam logic [3:0] OP_ADDLIT  = 4'hc;
    localparam logic [3:0] OP_XORLIT  = 4'hd;
    localparam logic [3:0] OP_TO_R    = 4'he;
    localparam logic [3:0] OP_FROM_R  = 4'hf;

    // bit-oriented operation, bits 10:9 when bit 11 is clear
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_TSC = 2'h2;
    localparam logic [1:0] BIT_TSS = 2'h3;

    // whole-word encodings
    localparam logic [13:0] WORD_SUBRET = 14'h0040;
    localparam logic [13:0] WORD_INTRET = 14'h0060;
    localparam logic [13:0] WORD_TABH   = 14'h0058;
    localparam logic [13:0] WORD_TABL   = 14'h0050;
    localparam logic [13:0] WORD_WDT    = 14'h1e04;
    localparam logic [13:0] WORD_SLEEP  = 14'h1e03;

    // field positions
    localparam int DEST_BIT = 7;
    localparam int BSEL_LSB = 6;

    // reset values and cycle counts
    localparam logic [7:0] W_RST    = 8'h00;
    localparam logic       TIME_OUT_RST   = 1'b1;
    localparam logic       POWER_DOWN_RST = 1'b1;
    localparam logic [1:0] CYC_ONE  = 2'h1;
    localparam logic [1:0] CYC_TWO  = 2'h2;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SECOND} seq_state_t;

    typedef struct packed {
        logic       rplane;
        logic [6:0] addr;
        logic       we;
        logic [7:0] wdata;
    } file_req_t;

    typedef struct packed {
        logic        skip;
        logic        push;
        logic        pop;
        logic        int_ret;
        logic        jump;
        logic [11:0] target;
    } flow_t;

    typedef struct packed {
        logic time_out_flag;
        logic power_down_flag;
        logic z;
        logic decimal_carry_flag;
        logic c;
    } status_t;

    typedef struct packed {
        logic       rd;
        logic [9:0] addr;
    } rom_req_t;

endpackage

// ===== instr_decoder_checker.sv
/* concurrent checks on instr_decoder ports: cycles, flow pulses, flags.
   assumes it is bound onto instr_decoder. */
`timescale 1ns/100ps
module instr_decoder_checker
    import instr_decoder_pkg::*;
(
    input wire logic        i_clk,         // clock
    input wire logic        i_reset_n,     // reset, active low
    input wire logic        i_instr_valid, // word offered
    input wire logic [13:0] i_instr,       // word
    input wire logic        o_ready,       // idle
    input wire flow_t       o_flow,        // flow requests
    input wire status_t     o_status,      // flags
    input wire logic        o_sleep,       // power-down pulse
    input wire logic        o_wdt_restart, // watchdog pulse
    input wire logic        o_done,        // retire pulse
    input wire logic [1:0]  o_cycles       // cycle count
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire take = o_ready && i_instr_valid;
    chk_lit_one:
        assert property (take && i_instr[13:8] == 6'h19 |-> ##2 o_done
            && o_cycles == CYC_ONE && o_status == $past(o_status)) else $error("load slow");
    chk_call_push:
        assert property (take && i_instr[13:12] == CLS_CALL |-> ##2 o_flow.push && o_flow.jump
            && o_flow.target == $past(i_instr[11:0], 2) ##1 o_done) else $error("call bad");
    chk_jump_two:
        assert property (take && i_instr[13:12] == CLS_JUMP |-> ##2 o_flow.jump && !o_flow.push
            ##1 o_done && o_cycles == CYC_TWO) else $error("jump bad");
    chk_ret_pop:
        assert property (take && i_instr == WORD_SUBRET |-> ##2 o_flow.pop && !o_flow.int_ret
            ##1 o_done && o_cycles == CYC_TWO) else $error("return bad");
    chk_int_ret:
        assert property (take && i_instr == WORD_INTRET |-> ##2 o_flow.pop && o_flow.int_ret)
        else $error("interrupt return bad");
    chk_sleep_pd:
        assert property (take && i_instr == WORD_SLEEP |-> ##2 o_sleep && o_done
            && o_status.time_out_flag && !o_status.power_down_flag) else $error("sleep bad");
    chk_wdt_flags:
        assert property (take && i_instr == WORD_WDT |-> ##2 o_wdt_restart && o_done
            && o_status.time_out_flag && o_status.power_down_flag) else $error("watchdog bad");
    chk_skip_two:
        assert property (o_flow.skip |=> o_done && o_cycles == CYC_TWO) else $error("skip bad");
    chk_ready_done:
        assert property ($rose(o_ready) |-> o_done) else $error("ready without done");
endmodule // instr_decoder_checker

bind instr_decoder instr_decoder_checker i_instr_decoder_checker (.*);

// ===== decoder_far_side.sv
/* register file and program memory model for the decoder's far side.
   assumes rom data is wanted in the cycle in which rd is high. */
`timescale 1ns/100ps
module decoder_far_side
    import instr_decoder_pkg::*;
(
    input  wire logic      i_clk,        // clock
    input  wire file_req_t i_file,       // file access
    output logic [7:0]     o_file_rdata, // file read data
    input  wire rom_req_t  i_rom,        // table read request
    output logic [13:0]    o_rom_data    // program word
);
    logic [7:0]  mem [128];
    logic [13:0] junk = 14'h0000;
    initial begin
        for (int a = 0; a < 128; a++) begin
            mem[a] = a[7:0];
        end
    end
    assign o_file_rdata = mem[i_file.addr];
    // word stands only while rd is high, a changing pattern otherwise
    assign o_rom_data = i_rom.rd ? {4'h2, i_rom.addr} : junk;
    always @(posedge i_clk) begin
        if (i_file.we) begin
            mem[i_file.addr] <= i_file.wdata;
        end
        junk <= ~junk;
    end
endmodule // decoder_far_side

// ===== mcu_instruction_decoder_tb.sv
/* table-driven bench for instr_decoder, then a reset in mid-instruction.
   assumes decoder_far_side answers file and rom requests. */
`timescale 1ns/100ps
module mcu_instruction_decoder_tb
    import instr_decoder_pkg::*;
;
    typedef struct packed {logic [13:0] instr; logic [7:0] w;
                           status_t st; logic [1:0] cyc;} row_t;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_instr_valid = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic        o_ready, o_done;
    logic [7:0]  o_w, file_rdata;
    logic [13:0] rom_data;
    logic [1:0]  o_cycles;
    status_t     o_status;
    file_req_t   file_req;
    rom_req_t    rom_req;
    int          mismatches = 0;
    int          comparisons = 0;
    row_t rows[30] = '{
    '{14'h193c, 8'h3c, 5'h18, 2'h1}, '{14'h1cc4, 8'h00, 5'h1f, 2'h1}, '{14'h1a81, 8'h81, 5'h1b, 2'h1},
    '{14'h1b7e, 8'h00, 5'h1f, 2'h1}, '{14'h1d5a, 8'h5a, 5'h1b, 2'h1}, '{14'h0d25, 8'h4b, 5'h1a, 2'h1},
    '{14'h0c21, 8'h10, 5'h1b, 2'h1}, '{14'h0230, 8'h20, 5'h1b, 2'h1}, '{14'h0210, 8'hf0, 5'h1a, 2'h1},
    '{14'h0050, 8'h23, 5'h1a, 2'h2}, '{14'h0058, 8'h09, 5'h1a, 2'h2}, '{14'h1e03, 8'h09, 5'h12, 2'h1},
    '{14'h1e04, 8'h09, 5'h1a, 2'h1}, '{14'h0b01, 8'h00, 5'h1a, 2'h2}, '{14'h0f7f, 8'h80, 5'h1a, 2'h1},
    '{14'h1855, 8'h55, 5'h1a, 2'h2}, '{14'h1402, 8'h55, 5'h1a, 2'h2}, '{14'h1642, 8'h55, 5'h1a, 2'h2},
    '{14'h1442, 8'h55, 5'h1a, 2'h1}, '{14'h13c3, 8'h55, 5'h1a, 2'h1}, '{14'h1003, 8'h55, 5'h1a, 2'h1},
    '{14'h0a84, 8'h55, 5'h1a, 2'h1}, '{14'h2abc, 8'h55, 5'h1a, 2'h2}, '{14'h3123, 8'h55, 5'h1a, 2'h2},
    '{14'h0040, 8'h55, 5'h1a, 2'h2}, '{14'h0060, 8'h55, 5'h1a, 2'h2}, '{14'h0e21, 8'h12, 5'h1a, 2'h1},
    '{14'h0140, 8'h00, 5'h1e, 2'h1}, '{14'h0760, 8'h60, 5'h18, 2'h1}, '{14'h0580, 8'h60, 5'h1c, 2'h1}};
    always #2.5 i_clk = ~i_clk;
    instr_decoder i_instr_decoder (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_ready(o_ready),
        .i_file_rdata(file_rdata), .o_file(file_req),
        .i_table_ptr(10'h123), .i_rom_data(rom_data), .o_rom(rom_req), .o_flow(), .o_w(o_w),
        .o_status(o_status), .o_sleep(), .o_wdt_restart(), .o_done(o_done), .o_cycles(o_cycles));
    decoder_far_side i_decoder_far_side (.i_clk(i_clk), .i_file(file_req),
        .o_file_rdata(file_rdata), .i_rom(rom_req), .o_rom_data(rom_data));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // word held valid until done, so the next one goes back to back
    task automatic run(input row_t r);
        i_instr = r.instr;
        i_instr_valid = 1'b1;
        @(negedge i_clk);
        for (int n = 0; n < 8 && o_done !== 1'b1; n++) @(negedge i_clk);
        if (o_done !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        check({o_done, o_w, o_status, o_cycles}, {1'b1, r.w, r.st, r.cyc});
    endtask
    initial begin
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b1;
        foreach (rows[k]) begin
            run(rows[k]);
            $display("row %0d ended", k);
        end
        check({8'h00, i_decoder_far_side.mem[3]}, 16'h0082);
        check({i_decoder_far_side.mem[1], i_decoder_far_side.mem[4]}, 16'h0105);
        i_instr = 14'h2abc;
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b0;
        @(negedge i_clk);
        check({o_ready, o_w, o_status, o_cycles},
              {1'b1, W_RST, TIME_OUT_RST, POWER_DOWN_RST, 5'h00});
        i_reset_n = 1'b1;
        run(rows[0]);
        $display("reset test ended");
        print_verdict();
    end
endmodule // mcu_instruction_decoder_tb
